//--- design/dio_defs.svh
// register offsets, field positions, reset values and timing counts
// assumes inclusion by the io unit module and its testbench only
`ifndef DIO_DEFS_SVH
`define DIO_DEFS_SVH
`define ADDR_GENERAL_CONFIG 16'h0065
`define ADDR_FLASH_SELECT 16'h0067
`define ADDR_FEATURE_CONFIG 16'h006a
`define ADDR_DISCRETE_OUTPUTS 16'h0410
`define ADDR_SPINDLE_DUTY 16'h0411
`define ADDR_WHEEL_COUNT_ONE 16'h047e
`define ADDR_DISCRETE_INPUTS 16'h047f
`define ADDR_WHEEL_COUNT_TWO 16'h0483
`define ADDR_READ_INTERVAL_TICKS 16'h0484
`define CONFIG_RESET 16'h0000
`define FEATURE_CONFIG_RESET 16'h0003
`define FEATURE_CONFIG_MASK 16'h008f
`define DOUT_RESET 8'h00
`define DUTY_RESET 10'h000
`define BIT_MODULATOR_OFF 7
`define BIT_WHEEL_ONE_ENABLE 0
`define BIT_WHEEL_TWO_ENABLE 1
`define BIT_WHEEL_ONE_DIVIDE 2
`define BIT_WHEEL_TWO_DIVIDE 3
`define BIT_SPINDLE_DIRECTION 2
`define BIT_SPINDLE_GATE 3
`define BIT_SPINDLE_PULSE 4
`define PIN_WHEEL_ONE_A 6
`define PIN_WHEEL_ONE_B 7
`define PIN_WHEEL_TWO_A 4
`define PIN_WHEEL_TWO_B 5
`define DUTY_FULL 10'h3ff
`define PWM_STEPS 1024
`define CLK_HZ 64'd200000000
`define CLK_PERIOD_NS 5
`define PWM_FREQ_CENTIHZ 64'd475
`define PWM_PERIOD_CYCLES ((`CLK_HZ * 64'd100) / `PWM_FREQ_CENTIHZ)
`define TICK_NS 1000
`define TICK_CYCLES (`TICK_NS / `CLK_PERIOD_NS)
`endif

//--- design/dio_pkg.sv
// types shared by the discrete io unit
// assumes dio_defs.svh is on the include path
package dio_pkg;
    typedef struct packed {
        logic wr;
        logic [15:0] addr;
        logic [15:0] wdata;
    } reg_req_t;
    typedef struct packed {
        logic step;
        logic up;
    } quad_step_t;
endpackage : dio_pkg

//--- design/discrete_io_pwm_encoder_unit.sv
// discrete outputs with safety timeout, spindle modulator, two wheel counters
// assumes one request per req pulse from the bus front end, inputs synchronous
`include "dio_defs.svh"

module discrete_io_pwm_encoder_unit
    import dio_pkg::*;
#(
    parameter int PWM_PERIOD_CYCLES = int'(`PWM_PERIOD_CYCLES)
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // register requests
    input wire logic req,
    input wire reg_req_t req_data,
    output logic rsp_valid,
    output logic [15:0] rsp_rdata,
    // safety timeout settings from outside
    input wire logic [31:0] pump_timeout_cycles,
    input wire logic [7:0] safety_pump_use,
    // pins
    input wire logic [7:0] din_pin_level,
    output logic [7:0] dout_pin_level,
    output logic [7:0] dout_led,
    output logic spindle_header
);

    localparam int SLOT_CYCLES = PWM_PERIOD_CYCLES / `PWM_STEPS;
    localparam int TICK_CYCLES = `TICK_CYCLES;

    function automatic quad_step_t quad_decode(input logic [1:0] prev, input logic [1:0] cur);
        quad_step_t r;
        r = '{step: 1'b0, up: 1'b0};
        case ({prev, cur})
            4'b0001, 4'b0111, 4'b1110, 4'b1000: r = '{step: 1'b1, up: 1'b1};
            4'b0010, 4'b1011, 4'b1101, 4'b0100: r = '{step: 1'b1, up: 1'b0};
            default: r = '{step: 1'b0, up: 1'b0};
        endcase
        return r;
    endfunction : quad_decode

    ////////////////////////////////////////////////////////////////////////////////
    // registers
    logic [15:0] general_config_q;
    logic [15:0] flash_select_q;
    logic [15:0] feature_config_q;
    logic [7:0] dout_q;
    logic [9:0] duty_q;
    logic [17:0] wheel_one_q;
    logic [17:0] wheel_two_q;
    logic [15:0] ticks_q;
    logic [15:0] tick_pre_q;
    logic [31:0] pump_cnt_q;
    logic pump_expire;
    logic wr_en;
    logic [7:0] din_state;
    logic [15:0] count_one;
    logic [15:0] count_two;
    logic mod_en;

    assign wr_en = req && req_data.wr;
    assign din_state = ~din_pin_level;
    assign mod_en = !feature_config_q[`BIT_MODULATOR_OFF];
    assign count_one = feature_config_q[`BIT_WHEEL_ONE_DIVIDE] ?
        wheel_one_q[17:2] : wheel_one_q[15:0];
    assign count_two = feature_config_q[`BIT_WHEEL_TWO_DIVIDE] ?
        wheel_two_q[17:2] : wheel_two_q[15:0];

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            general_config_q <= `CONFIG_RESET;
            flash_select_q <= `CONFIG_RESET;
            feature_config_q <= `FEATURE_CONFIG_RESET;
            duty_q <= `DUTY_RESET;
        end else if (wr_en) begin
            case (req_data.addr)
                `ADDR_GENERAL_CONFIG: general_config_q <= req_data.wdata;
                `ADDR_FLASH_SELECT: flash_select_q <= req_data.wdata;
                `ADDR_FEATURE_CONFIG: feature_config_q <= req_data.wdata & `FEATURE_CONFIG_MASK;
                `ADDR_SPINDLE_DUTY: duty_q <= req_data.wdata[9:0];
                default: ;
            endcase
        end
    end

    // discrete outputs, write wins over timeout drop
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            dout_q <= `DOUT_RESET;
        end else if (wr_en && req_data.addr == `ADDR_DISCRETE_OUTPUTS) begin
            dout_q <= req_data.wdata[7:0];
        end else if (pump_expire) begin
            dout_q <= dout_q & ~safety_pump_use;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // safety timeout
    assign pump_expire = !req && pump_timeout_cycles != 32'h0 &&
        pump_cnt_q == pump_timeout_cycles - 32'h1;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pump_cnt_q <= 32'h0;
        end else if (req) begin
            pump_cnt_q <= 32'h0;
        end else if (pump_cnt_q < pump_timeout_cycles) begin
            pump_cnt_q <= pump_cnt_q + 32'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // spindle modulator
    logic [31:0] slot_q;
    logic [9:0] step_q;
    logic pwm_active;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            slot_q <= 32'h0;
            step_q <= 10'h0;
        end else if (slot_q == 32'(SLOT_CYCLES - 1)) begin
            slot_q <= 32'h0;
            step_q <= step_q + 10'h1;
        end else begin
            slot_q <= slot_q + 32'h1;
        end
    end

    assign pwm_active = !dout_q[`BIT_SPINDLE_GATE] &&
        (duty_q == `DUTY_FULL || step_q < duty_q);

    ////////////////////////////////////////////////////////////////////////////////
    // wheel counters
    logic [1:0] ph_one_q;
    logic [1:0] ph_two_q;
    quad_step_t st_one;
    quad_step_t st_two;
    logic [1:0] ph_one;
    logic [1:0] ph_two;

    assign ph_one = {din_state[`PIN_WHEEL_ONE_A], din_state[`PIN_WHEEL_ONE_B]};
    assign ph_two = {din_state[`PIN_WHEEL_TWO_A], din_state[`PIN_WHEEL_TWO_B]};
    assign st_one = quad_decode(ph_one_q, ph_one);
    assign st_two = quad_decode(ph_two_q, ph_two);

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ph_one_q <= 2'b00;
            ph_two_q <= 2'b00;
        end else begin
            ph_one_q <= ph_one;
            ph_two_q <= ph_two;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wheel_one_q <= 18'h0;
        end else if (feature_config_q[`BIT_WHEEL_ONE_ENABLE] && st_one.step) begin
            wheel_one_q <= st_one.up ? wheel_one_q + 18'h1 : wheel_one_q - 18'h1;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wheel_two_q <= 18'h0;
        end else if (feature_config_q[`BIT_WHEEL_TWO_ENABLE] && st_two.step) begin
            wheel_two_q <= st_two.up ? wheel_two_q + 18'h1 : wheel_two_q - 18'h1;
        end
    end

    // tick timer, saturating, restarted by a count read
    logic count_read;
    assign count_read = req && !req_data.wr && (req_data.addr == `ADDR_WHEEL_COUNT_ONE ||
        req_data.addr == `ADDR_WHEEL_COUNT_TWO);

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            tick_pre_q <= 16'h0;
            ticks_q <= 16'h0;
        end else if (count_read) begin
            tick_pre_q <= 16'h0;
            ticks_q <= 16'h0;
        end else if (tick_pre_q == 16'(TICK_CYCLES - 1)) begin
            tick_pre_q <= 16'h0;
            if (ticks_q != 16'hffff) begin
                ticks_q <= ticks_q + 16'h1;
            end
        end else begin
            tick_pre_q <= tick_pre_q + 16'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read answer
    logic [15:0] rdata_d;
    always_comb begin
        case (req_data.addr)
            `ADDR_GENERAL_CONFIG: rdata_d = general_config_q;
            `ADDR_FLASH_SELECT: rdata_d = flash_select_q;
            `ADDR_FEATURE_CONFIG: rdata_d = feature_config_q;
            `ADDR_DISCRETE_OUTPUTS: rdata_d = {8'h00, dout_q};
            `ADDR_SPINDLE_DUTY: rdata_d = {6'h00, duty_q};
            `ADDR_WHEEL_COUNT_ONE: rdata_d = count_one;
            `ADDR_DISCRETE_INPUTS: rdata_d = {8'h00, din_state};
            `ADDR_WHEEL_COUNT_TWO: rdata_d = count_two;
            `ADDR_READ_INTERVAL_TICKS: rdata_d = ticks_q;
            default: rdata_d = 16'h0000;
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rsp_valid <= 1'b0;
            rsp_rdata <= 16'h0000;
        end else begin
            rsp_valid <= req;
            rsp_rdata <= (req && !req_data.wr) ? rdata_d : 16'h0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // pins
    logic [7:0] act_d;
    always_comb begin
        act_d = dout_q;
        if (mod_en) begin
            act_d[`BIT_SPINDLE_PULSE] = pwm_active;
            act_d[`BIT_SPINDLE_GATE] = !dout_q[`BIT_SPINDLE_GATE];
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            dout_pin_level <= 8'hff;
            dout_led <= 8'h00;
            spindle_header <= 1'b0;
        end else begin
            dout_pin_level <= ~act_d;
            dout_led <= act_d;
            spindle_header <= mod_en && pwm_active;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_dout_write;
        req && req_data.wr && req_data.addr == `ADDR_DISCRETE_OUTPUTS;
    endsequence
    sequence s_quiet_expire;
        pump_expire && !req;
    endsequence

    a_read_answer: assert property (@(posedge clk) disable iff (reset)
        req |=> rsp_valid ##1 (!rsp_valid || $past(req)))
        else $error("no answer one cycle after request");
    a_dout_write: assert property (@(posedge clk) disable iff (reset)
        s_dout_write |=> dout_q == $past(req_data.wdata[7:0]))
        else $error("output write not stored");
    a_pump_drop: assert property (@(posedge clk) disable iff (reset)
        s_quiet_expire |=> (dout_q & $past(safety_pump_use)) == 8'h00)
        else $error("timed out output not dropped");
    a_pump_spare: assert property (@(posedge clk) disable iff (reset)
        s_quiet_expire |=> (dout_q & ~$past(safety_pump_use)) ==
            ($past(dout_q) & ~$past(safety_pump_use)))
        else $error("output without timeout disturbed");
    a_pump_restart: assert property (@(posedge clk) disable iff (reset)
        req |=> pump_cnt_q == 32'h0 && (!pump_expire || pump_timeout_cycles == 32'h1))
        else $error("timeout counter not restarted");
    a_gate_zero: assert property (@(posedge clk) disable iff (reset)
        dout_q[`BIT_SPINDLE_GATE] |=> !spindle_header &&
            (!$past(mod_en) || dout_pin_level[`BIT_SPINDLE_PULSE]))
        else $error("gated modulator still active");
    a_duty_full: assert property (@(posedge clk) disable iff (reset)
        mod_en && duty_q == `DUTY_FULL && !dout_q[`BIT_SPINDLE_GATE] |=>
            spindle_header && !dout_pin_level[`BIT_SPINDLE_PULSE])
        else $error("full duty not fully active");
    a_plain_pins: assert property (@(posedge clk) disable iff (reset)
        !mod_en |=> dout_pin_level == ~$past(dout_q) && dout_led == $past(dout_q))
        else $error("plain outputs wrong on pins");
    a_wheel_wrap: assert property (@(posedge clk) disable iff (reset)
        feature_config_q[`BIT_WHEEL_ONE_ENABLE] && st_one.step && st_one.up &&
            wheel_one_q[15:0] == 16'hffff |=> wheel_one_q[15:0] == 16'h0000)
        else $error("wheel count did not wrap");
    a_tick_restart: assert property (@(posedge clk) disable iff (reset)
        count_read |=> ticks_q == 16'h0000 ##1 ticks_q <= 16'h0001)
        else $error("tick timer not restarted by read");

endmodule : discrete_io_pwm_encoder_unit

//--- tb/bus_master_model.sv
// bus master model: one register request per call, answer awaited
// assumes the io unit answers within four cycles of taking a request
module bus_master_model
    import dio_pkg::*;
(
    // clock
    input wire logic clk,
    // request side
    output logic req,
    output reg_req_t req_data,
    // answer side
    input wire logic rsp_valid,
    input wire logic [15:0] rsp_rdata
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        req = 1'b0;
        req_data = '0;
    end

    // one pulse per request, released lines show inverted data
    task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d,
                        output logic [15:0] rd);
        int k;
        @(posedge clk);
        #1;
        req = 1'b1;
        req_data = '{wr: w, addr: a, wdata: d};
        @(posedge clk);
        #1;
        req = 1'b0;
        req_data = ~req_data;
        for (k = 0; k < 4 && rsp_valid !== 1'b1; k++) begin
            @(posedge clk);
            #1;
        end
        rd = rsp_rdata;
    endtask : xfer
endmodule : bus_master_model

//--- tb/tb_discrete_io_pwm_encoder_unit.sv
// testbench for the discrete io unit: registers, timeout, modulator, wheels
// assumes a short modulator period of 4096 cycles (slot of 4 cycles)
`include "dio_defs.svh"
module tb_discrete_io_pwm_encoder_unit
    import dio_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int PER = 4096;
    logic clk, reset, req, rsp_valid, spindle_header;
    reg_req_t req_data;
    logic [15:0] rsp_rdata, rd;
    logic [31:0] pump_timeout_cycles;
    logic [7:0] safety_pump_use, din_pin_level, dout_pin_level, dout_led;
    int num_errors = 0;
    int num_checks = 0;
    int ph [2] = '{0, 0};
    int i;
    logic [1:0] gray [4] = '{2'b00, 2'b01, 2'b11, 2'b10};
    logic [15:0] duty [4] = '{16'h0000, 16'h0100, 16'h0200, 16'h03ff};
    int hi [4] = '{0, 1024, 2048, 4096};

    ////////////////////////////////////////////////////////////////////////
    discrete_io_pwm_encoder_unit #(.PWM_PERIOD_CYCLES(PER)) discrete_io_pwm_encoder_unit_i (
        .clk(clk), .reset(reset), .req(req), .req_data(req_data),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .pump_timeout_cycles(pump_timeout_cycles), .safety_pump_use(safety_pump_use),
        .din_pin_level(din_pin_level), .dout_pin_level(dout_pin_level),
        .dout_led(dout_led), .spindle_header(spindle_header));
    bus_master_model bus_master_model_i (
        .clk(clk), .req(req), .req_data(req_data),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        bus_master_model_i.xfer(1'b1, a, d, rd);
        chk("write rsp_valid", 16'h0001, {15'h0, rsp_valid});
        chk("write rdata", 16'h0000, rd);
    endtask : wr
    task automatic rdchk(input string what, input logic [15:0] a, input logic [15:0] exp);
        bus_master_model_i.xfer(1'b0, a, 16'h0000, rd);
        chk("read rsp_valid", 16'h0001, {15'h0, rsp_valid});
        chk(what, exp, rd);
    endtask : rdchk
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : idle
    // wheel steps (w 0 on inputs 6/7, w 1 on inputs 4/5), spaced under the rate limit
    task automatic turn(input int w, input int n, input bit up);
        repeat (n) begin
            ph[w] = up ? (ph[w] + 1) % 4 : (ph[w] + 3) % 4;
            din_pin_level[(w == 0 ? 6 : 4) +: 2] = ~{gray[ph[w]][0], gray[ph[w]][1]};
            idle(8);
        end
    endtask : turn
    task automatic pwm(input string what, input int exp_hi, input logic gate_pin);
        int h;
        int bad;
        h = 0;
        bad = 0;
        idle(8);
        repeat (PER) begin
            idle(1);
            h += (spindle_header === 1'b1);
            bad += (dout_pin_level[4] !== ~spindle_header) || (dout_pin_level[3] !== gate_pin);
        end
        chk({what, " high"}, 16'(exp_hi), 16'(h));
        chk({what, " pins"}, 16'h0000, 16'(bad));
    endtask : pwm
    task automatic finish_test;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : finish_test

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (50000) @(posedge clk);
        num_errors++;
        finish_test;
    end

    initial begin
        reset = 1'b1;
        din_pin_level = 8'hff;
        pump_timeout_cycles = 32'h0;
        safety_pump_use = 8'h00;
        repeat (12) @(posedge clk);
        #1;
        reset = 1'b0;
        rdchk("feature_config", `ADDR_FEATURE_CONFIG, 16'h0003);
        rdchk("unmapped", 16'h0400, 16'h0000);
        wr(`ADDR_GENERAL_CONFIG, 16'ha5c3);
        rdchk("general_config", `ADDR_GENERAL_CONFIG, 16'ha5c3);
        wr(`ADDR_FLASH_SELECT, 16'h5a3c);
        rdchk("flash_select", `ADDR_FLASH_SELECT, 16'h5a3c);
        wr(`ADDR_FEATURE_CONFIG, 16'hff7f);
        rdchk("feature_config mask", `ADDR_FEATURE_CONFIG, 16'h000f);
        wr(`ADDR_FEATURE_CONFIG, 16'h0003);
        wr(`ADDR_WHEEL_COUNT_ONE, 16'h1234);
        rdchk("count ro", `ADDR_WHEEL_COUNT_ONE, 16'h0000);
        din_pin_level = 8'hf5;
        idle(3);
        rdchk("inputs a", `ADDR_DISCRETE_INPUTS, 16'h000a);
        din_pin_level = 8'hfa;
        idle(3);
        rdchk("inputs b", `ADDR_DISCRETE_INPUTS, 16'h0005);
        din_pin_level = 8'hff;
        $display("test registers done");
        wr(`ADDR_DISCRETE_OUTPUTS, 16'hff27);
        idle(3);
        chk("dout pins", 16'h00d0, {8'h00, dout_pin_level});
        chk("dout leds", 16'h0027, {8'h00, dout_led & 8'he7});
        rdchk("dout", `ADDR_DISCRETE_OUTPUTS, 16'h0027);
        pump_timeout_cycles = 32'd50;
        safety_pump_use = 8'h21;
        wr(`ADDR_DISCRETE_OUTPUTS, 16'h0023);
        idle(40);
        rdchk("dout", `ADDR_DISCRETE_OUTPUTS, 16'h0023);
        idle(40);
        chk("restart", 16'h0000, {15'h0, dout_pin_level[0]});
        idle(20);
        chk("expired", 16'h0005, {13'h0, dout_pin_level[5], dout_pin_level[1:0]});
        rdchk("dout dropped", `ADDR_DISCRETE_OUTPUTS, 16'h0002);
        pump_timeout_cycles = 32'h0;
        wr(`ADDR_DISCRETE_OUTPUTS, 16'h0015);
        idle(3);
        chk("rewritten", 16'h0000, {15'h0, dout_pin_level[0]});
        $display("test outputs done");
        for (i = 0; i < 4; i++) begin
            wr(`ADDR_SPINDLE_DUTY, 16'hfc00 | duty[i]);
            rdchk("spindle_duty", `ADDR_SPINDLE_DUTY, duty[i]);
            pwm("duty", hi[i], 1'b0);
        end
        wr(`ADDR_DISCRETE_OUTPUTS, 16'h001d);
        pwm("gated", 0, 1'b1);
        wr(`ADDR_FEATURE_CONFIG, 16'h0083);
        idle(4);
        chk("off pins", 16'h00e2, {8'h00, dout_pin_level});
        chk("off header", 16'h0000, {15'h0, spindle_header});
        $display("test modulator done");
        wr(`ADDR_FEATURE_CONFIG, 16'h0003);
        turn(0, 4, 1'b1);
        rdchk("count up", `ADDR_WHEEL_COUNT_ONE, 16'h0004);
        idle(1100);
        rdchk("ticks", `ADDR_READ_INTERVAL_TICKS, 16'h0005);
        turn(0, 5, 1'b0);
        rdchk("count wrap", `ADDR_WHEEL_COUNT_ONE, 16'hffff);
        wr(`ADDR_FEATURE_CONFIG, 16'h0007);
        turn(0, 8, 1'b1);
        rdchk("count div", `ADDR_WHEEL_COUNT_ONE, 16'h0001);
        wr(`ADDR_FEATURE_CONFIG, 16'h0006);
        turn(0, 4, 1'b1);
        rdchk("count held", `ADDR_WHEEL_COUNT_ONE, 16'h0001);
        turn(1, 3, 1'b0);
        rdchk("count two", `ADDR_WHEEL_COUNT_TWO, 16'hfffd);
        wr(`ADDR_FEATURE_CONFIG, 16'h000e);
        rdchk("count two div", `ADDR_WHEEL_COUNT_TWO, 16'hffff);
        rdchk("count one kept", `ADDR_WHEEL_COUNT_ONE, 16'h0001);
        $display("test wheels done");
        finish_test;
    end
endmodule : tb_discrete_io_pwm_encoder_unit
